// ### inc/dmc_cfg.svh
// Timing, width and count constants for the multiplexed dynamic memory controller.
`ifndef DMC_CFG_SVH
`define DMC_CFG_SVH
// Clock period in picoseconds (200 MHz).
`define DMC_CLK_PS 5000
// Host address width, then address and data widths at the memory pins.
`define DMC_ADDR_W 16
`define DMC_PIN_W 8
`define DMC_DATA_W 8
// Row count and refresh period.
`define DMC_ROWS 128
`define DMC_REF_PERIOD_NS 2000000
// Power-up pause and number of dummy cycles.
`define DMC_POWERUP_NS 500000
`define DMC_DUMMY_CYCLES 8
// Least times in nanoseconds.
`define DMC_T_RP_NS 100
`define DMC_T_RAS_NS 150
`define DMC_T_RAH_NS 20
`define DMC_T_RCD_NS 30
`define DMC_T_CAS_NS 75
`define DMC_T_CAC_NS 75
`define DMC_T_CP_NS 60
`define DMC_T_FP_NS 60
`define DMC_T_FC_NS 260
`define DMC_T_FBP_NS 8000
`define DMC_T_FBR_NS 295
// Longest time in nanoseconds: row strobe low.
`define DMC_T_RAS_MAX_NS 10000
// Cycles kept in reserve before the row strobe limit when holding a page.
`define DMC_RAS_GUARD_CYC 64
// Synchroniser depth on the data pins.
`define DMC_SYNC_STAGES 2
`endif

// ### inc/dmc_pkg.sv
// Types shared by the dynamic memory controller modules.
`default_nettype none
package dmc_pkg;
    // Sequencer states, Gray coded along IDLE-RAS-CAS-PAGE-PRE-REF_LOW-REF_REC.
    typedef enum logic [3:0] {
        DMC_IDLE = 4'h0,
        DMC_RAS = 4'h1,
        DMC_CAS = 4'h3,
        DMC_PAGE = 4'h2,
        DMC_PRE = 4'h6,
        DMC_REF_LOW = 4'h7,
        DMC_REF_REC = 4'h5,
        DMC_SELF = 4'h4,
        DMC_INIT_WAIT = 4'hC
    } dmc_state_e;
endpackage : dmc_pkg
`default_nettype wire

// ### inc/dmc_ref_if.sv
// Link between the refresh interval timer and the sequencer.
`timescale 1ns/1ps
`default_nettype none
interface dmc_ref_if;
    logic due;
    logic done;
    modport timer (output due, input done);
    modport ctrl (input due, output done);
endinterface : dmc_ref_if
`default_nettype wire

// ### hw/dmc_refresh_timer.sv
// Refresh interval timer: raises a due flag once per row interval.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_cfg.svh"
module dmc_refresh_timer import dmc_pkg::*; #(
    parameter int INT_CYC = (`DMC_REF_PERIOD_NS / `DMC_ROWS) * 1000 / `DMC_CLK_PS
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    dmc_ref_if.timer ref_if
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic due_q;
    logic due_d;

    // The interval runs freely, so a refresh that starts late does not push back the
    // next one and the average rate holds; a tick beside a completed refresh still sets due.
    always_comb begin
        logic tick;
        tick = (cnt_q >= 16'(INT_CYC - 1));
        cnt_d = tick ? 16'h0000 : cnt_q + 16'h0001;
        due_d = tick || (due_q && !ref_if.done);
    end

    // State registers, frozen while the clock enable is low.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 16'h0000;
            due_q <= 1'b0;
        end else if (ce_i) begin
            cnt_q <= cnt_d;
            due_q <= due_d;
        end
    end

    assign ref_if.due = due_q;
endmodule : dmc_refresh_timer
`default_nettype wire

// ### hw/dmc_ctrl.sv
// Host sequencer that drives a multiplexed-address dynamic memory through its pins.
// Summary of operation
// (RULE_01) Shared data bus is allowed only because every write is an early write.
// (RULE_02) Read data stays available between reads without stretching the cycle.
// (RULE_03) Outputs unlatched; either strobe may serve as chip select.
// (RULE_04) Pages beyond 256 columns need the row strobe on every device.
// (RULE_05) Page mode: row strobed once, held low, new column strobes per access.
// (RULE_06) All 128 rows must be refreshed within every 2 ms.
// (RULE_07) Any read or write cycle refreshes the latched row.
// (RULE_08) Avoid plain read or write cycles as refresh on wire-ORed outputs.
// (RULE_09) Row-strobe-only cycles refresh with data outputs kept off.
// (RULE_10) Automatic refresh: refresh pin low after precharge, device supplies row.
// (RULE_11) Device steps its refresh counter after each automatic refresh.
// (RULE_12) Refresh counter settles within the first eight strobe cycles.
// (RULE_13) Row strobe and refresh pin never active in each other's cycles.
// (RULE_14) Refresh pin held low with row strobe high gives self refresh.
// (RULE_15) Self refresh covers every row within 2 ms without external timing.
// (RULE_16) Refresh pin pulls itself high when left open.
// (RULE_17) Hidden refresh: column strobe stays low, row strobe precharges, refresh runs.
// (RULE_18) Read data stays valid during hidden refresh while column strobe is low.
// (RULE_19) Decoding the row strobe puts unselected devices into standby.
// (RULE_20) Wait 500 us after power-up, then eight dummy cycles before use.
// (RULE_21) Row byte latched on row strobe fall, column byte on column strobe fall.
// (RULE_22) Write data is taken on the later falling edge of write or column strobe.
// (RULE_23) Data pins float while column strobe is high.
// (RULE_24) Data pins stay floating throughout an early write.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_cfg.svh"
module dmc_ctrl import dmc_pkg::*; #(
    parameter int POWERUP_CYC = `DMC_POWERUP_NS / (`DMC_CLK_PS / 1000)
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [`DMC_ADDR_W-1:0] addr_i,
    input wire logic [`DMC_DATA_W-1:0] wdata_i,
    input wire logic keep_page_i,
    input wire logic sleep_i,
    output logic ready_o,
    output logic done_o,
    output logic rvalid_o,
    output logic [`DMC_DATA_W-1:0] rdata_o,
    output logic init_done_o,
    output logic row_strobe_n_o,
    output logic col_strobe_n_o,
    output logic write_n_o,
    output logic refresh_n_o,
    output logic [`DMC_PIN_W-1:0] addr_o,
    output logic [`DMC_DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic [`DMC_DATA_W-1:0] dq_i
);
    // Least times round up to whole cycles.
    function automatic int cyc_up(input int ns);
        return (ns * 1000 + `DMC_CLK_PS - 1) / `DMC_CLK_PS;
    endfunction : cyc_up

    localparam int RpCyc = cyc_up(`DMC_T_RP_NS);
    localparam int RasMinCyc = cyc_up(`DMC_T_RAS_NS);
    localparam int RasMaxCyc = (`DMC_T_RAS_MAX_NS * 1000) / `DMC_CLK_PS;
    localparam int RahCyc = cyc_up(`DMC_T_RAH_NS);
    localparam int RcdCyc = cyc_up(`DMC_T_RCD_NS);
    localparam int CasCyc = cyc_up(`DMC_T_CAS_NS);
    localparam int CacCyc = cyc_up(`DMC_T_CAC_NS);
    localparam int CpCyc = cyc_up(`DMC_T_CP_NS);
    localparam int FpCyc = cyc_up(`DMC_T_FP_NS);
    localparam int RecCyc = cyc_up(`DMC_T_FC_NS) - FpCyc;
    localparam int SelfMinCyc = cyc_up(`DMC_T_FBP_NS);
    localparam int SelfExitCyc = cyc_up(`DMC_T_FBR_NS);
    localparam int RdCyc = CacCyc + `DMC_SYNC_STAGES + 1;
    localparam int CasHoldCyc = (RdCyc > CasCyc) ? RdCyc : CasCyc;
    localparam int PageLimCyc = RasMaxCyc - `DMC_RAS_GUARD_CYC;

    dmc_ref_if ref_if ();

    dmc_state_e st_q, st_d;
    logic [19:0] cnt_q, cnt_d;
    logic [11:0] ras_cnt_q, ras_cnt_d;
    logic [3:0] dum_q, dum_d;
    logic ras_n_q, ras_n_d, cas_n_q, cas_n_d, wr_n_q, wr_n_d, ref_n_q, ref_n_d;
    logic oe_q, oe_d, we_q, we_d, pend_q, pend_d, hide_q, hide_d, self_q, self_d;
    logic done_q, done_d, rvalid_q, rvalid_d, refd_q, refd_d;
    logic [`DMC_PIN_W-1:0] pin_q, pin_d, row_q, row_d, col_q, col_d;
    logic [`DMC_DATA_W-1:0] dq_q, dq_d, wd_q, wd_d, rd_q, rd_d;
    logic [`DMC_DATA_W-1:0] dq_m_q, dq_s_q;
    logic init_done, page_ok, row_hit, take;

    ////////////////////////////////////////////////////////////////////////////////
    // Refresh interval timer.
    dmc_refresh_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .ref_if(ref_if.timer)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Data pins pass two flops; only the second is ever sampled.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dq_m_q <= 8'h00;
            dq_s_q <= 8'h00;
        end else if (ce_i) begin
            dq_m_q <= dq_i;
            dq_s_q <= dq_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request acceptance is combinational so a page hit costs no extra cycle.
    assign init_done = (dum_q == 4'(`DMC_DUMMY_CYCLES)); // RULE_20 RULE_12
    assign row_hit = (addr_i[`DMC_PIN_W-1:0] == row_q);
    // A page is kept only while there is budget left under the row strobe limit.
    assign page_ok = keep_page_i && !ref_if.due && !sleep_i
                     && (ras_cnt_q < 12'(PageLimCyc)); // RULE_05
    always_comb begin
        ready_o = 1'b0;
        if (ce_i && st_q == DMC_IDLE) begin
            ready_o = init_done && !ref_if.due && !sleep_i;
        end else if (ce_i && st_q == DMC_PAGE) begin
            ready_o = !pend_q && page_ok && row_hit && (cnt_q >= 20'(CpCyc - 1));
        end
    end
    assign take = req_i && ready_o;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer next-state logic; every pin value is registered.
    always_comb begin
        st_d = st_q;
        cnt_d = (&cnt_q) ? cnt_q : cnt_q + 20'h00001;
        ras_cnt_d = ras_n_q ? 12'h000 : ras_cnt_q + 12'h001;
        dum_d = dum_q;
        ras_n_d = ras_n_q;
        cas_n_d = cas_n_q;
        wr_n_d = wr_n_q;
        ref_n_d = ref_n_q;
        oe_d = oe_q;
        we_d = we_q;
        pend_d = pend_q;
        hide_d = hide_q;
        self_d = self_q;
        pin_d = pin_q;
        row_d = row_q;
        col_d = col_q;
        dq_d = dq_q;
        wd_d = wd_q;
        rd_d = rd_q;
        done_d = 1'b0;
        rvalid_d = 1'b0;
        refd_d = 1'b0;
        unique case (st_q)
            DMC_INIT_WAIT: begin
                // Power-up pause before any strobe moves.
                if (cnt_q >= 20'(POWERUP_CYC - 1)) begin // RULE_20
                    st_d = DMC_IDLE;
                end
            end
            DMC_IDLE: begin
                // Row strobe has been high for a full precharge when this state is reached.
                if (!init_done || ref_if.due) begin
                    ref_n_d = 1'b0; // RULE_10 RULE_06 RULE_08 RULE_12
                    st_d = DMC_REF_LOW;
                end else if (sleep_i) begin
                    ref_n_d = 1'b0; // RULE_14
                    self_d = 1'b1;
                    st_d = DMC_SELF;
                end else if (take) begin
                    ras_n_d = 1'b0;
                    pin_d = addr_i[`DMC_PIN_W-1:0]; // RULE_21
                    row_d = addr_i[`DMC_PIN_W-1:0];
                    col_d = addr_i[`DMC_ADDR_W-1:`DMC_PIN_W];
                    we_d = we_i;
                    wd_d = wdata_i;
                    st_d = DMC_RAS;
                end
            end
            DMC_RAS: begin
                // Column byte follows the row hold; write strobe leads the column strobe.
                if (cnt_q == 20'(RahCyc - 1)) begin
                    pin_d = col_q; // RULE_21
                    if (we_q) begin
                        wr_n_d = 1'b0; // RULE_01 RULE_22
                        oe_d = 1'b1;
                        dq_d = wd_q;
                    end
                end
                if (cnt_q >= 20'(RcdCyc - 1)) begin
                    cas_n_d = 1'b0;
                    cnt_d = 20'h00000;
                    st_d = DMC_CAS;
                end
            end
            DMC_CAS: begin
                // Read data is sampled after access time plus the synchroniser delay,
                // while the column strobe is still low and the pins are driven.
                if (cnt_q >= 20'(CasHoldCyc - 1)) begin
                    done_d = 1'b1;
                    if (!we_q) begin
                        rd_d = dq_s_q; // RULE_23 RULE_02
                        rvalid_d = 1'b1;
                    end
                    if (!we_q && ref_if.due && ras_cnt_q >= 12'(RasMinCyc - 1)) begin
                        ras_n_d = 1'b1; // RULE_17
                        hide_d = 1'b1;
                        st_d = DMC_PRE;
                    end else begin
                        cas_n_d = 1'b1;
                        wr_n_d = 1'b1;
                        oe_d = 1'b0;
                        st_d = DMC_PAGE;
                    end
                    cnt_d = 20'h00000;
                end
            end
            DMC_PAGE: begin
                // Row stays open; each further access only needs a column strobe.
                if (pend_q) begin
                    cas_n_d = 1'b0; // RULE_05
                    pend_d = 1'b0;
                    cnt_d = 20'h00000;
                    st_d = DMC_CAS;
                end else if (take) begin
                    pin_d = addr_i[`DMC_ADDR_W-1:`DMC_PIN_W];
                    we_d = we_i;
                    pend_d = 1'b1;
                    if (we_i) begin
                        wr_n_d = 1'b0; // RULE_22 RULE_24
                        oe_d = 1'b1;
                        dq_d = wdata_i;
                    end
                end else if ((!page_ok || (req_i && !row_hit))
                             && cnt_q >= 20'(CpCyc - 1)
                             && ras_cnt_q >= 12'(RasMinCyc - 1)) begin
                    ras_n_d = 1'b1;
                    cnt_d = 20'h00000;
                    st_d = DMC_PRE;
                end
            end
            DMC_PRE: begin
                // Precharge; when entered for a hidden refresh, the refresh follows with the column strobe still low.
                if (cnt_q >= 20'(RpCyc - 1)) begin
                    cnt_d = 20'h00000;
                    if (hide_q) begin
                        ref_n_d = 1'b0; // RULE_17 RULE_18 RULE_10
                        st_d = DMC_REF_LOW;
                    end else begin
                        st_d = DMC_IDLE;
                    end
                end
            end
            DMC_REF_LOW: begin
                // Refresh pulse; the device supplies and then steps the row itself.
                if (cnt_q >= 20'(FpCyc - 1)) begin
                    ref_n_d = 1'b1; // RULE_11
                    cas_n_d = 1'b1;
                    hide_d = 1'b0;
                    refd_d = 1'b1;
                    if (!init_done) begin
                        dum_d = dum_q + 4'h1; // RULE_12
                    end
                    cnt_d = 20'h00000;
                    st_d = DMC_REF_REC;
                end
            end
            DMC_SELF: begin
                // Refresh pin held low with row strobe high; the device times itself.
                if (!sleep_i && cnt_q >= 20'(SelfMinCyc - 1)) begin
                    ref_n_d = 1'b1; // RULE_14 RULE_15
                    refd_d = 1'b1;
                    cnt_d = 20'h00000;
                    st_d = DMC_REF_REC;
                end
            end
            DMC_REF_REC: begin
                // Recovery after the refresh pin rises before the row strobe may fall.
                if (cnt_q >= (self_q ? 20'(SelfExitCyc - 1) : 20'(RecCyc - 1))) begin // RULE_13
                    self_d = 1'b0;
                    st_d = DMC_IDLE;
                end
            end
            default: begin
                st_d = DMC_IDLE;
            end
        endcase
        if (st_d != st_q) begin
            cnt_d = 20'h00000;
        end
    end

    assign ref_if.done = refd_q;

    ////////////////////////////////////////////////////////////////////////////////
    // State registers; all strobes reset inactive with the data pins released.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= DMC_INIT_WAIT;
            cnt_q <= 20'h00000;
            ras_cnt_q <= 12'h000;
            dum_q <= 4'h0;
            {ras_n_q, cas_n_q, wr_n_q, ref_n_q} <= 4'hF;
            {oe_q, we_q, pend_q, hide_q, self_q} <= 5'h00;
            {done_q, rvalid_q, refd_q} <= 3'h0;
            {pin_q, row_q, col_q} <= 24'h000000;
            {dq_q, wd_q, rd_q} <= 24'h000000;
        end else if (ce_i) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ras_cnt_q <= ras_cnt_d;
            dum_q <= dum_d;
            {ras_n_q, cas_n_q, wr_n_q, ref_n_q} <= {ras_n_d, cas_n_d, wr_n_d, ref_n_d};
            {oe_q, we_q, pend_q, hide_q, self_q} <= {oe_d, we_d, pend_d, hide_d, self_d};
            {done_q, rvalid_q, refd_q} <= {done_d, rvalid_d, refd_d};
            {pin_q, row_q, col_q} <= {pin_d, row_d, col_d};
            {dq_q, wd_q, rd_q} <= {dq_d, wd_d, rd_d};
        end
    end

    // Single device: both strobes double as its select, so no decode is needed here.
    assign row_strobe_n_o = ras_n_q; // RULE_03 RULE_19 RULE_04
    assign col_strobe_n_o = cas_n_q;
    assign write_n_o = wr_n_q;
    assign refresh_n_o = ref_n_q;
    assign addr_o = pin_q;
    assign dq_o = dq_q;
    assign dq_oe_o = oe_q;
    assign rdata_o = rd_q;
    assign rvalid_o = rvalid_q;
    assign done_o = done_q;
    assign init_done_o = init_done;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks. Helper counter of cycles spent with a refresh outstanding.
    // Self refresh and the power-up pause are left out: no row is owed to the host then.
    logic [11:0] late_q;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            late_q <= 12'h000;
        end else if (ce_i) begin
            late_q <= (ref_if.due && !self_q && st_q != DMC_INIT_WAIT) ? late_q + 12'h001 : 12'h000;
        end
    end

    property p_excl;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        !refresh_n_o |-> row_strobe_n_o;
    endproperty
    a_excl: assert property (p_excl) else $error("row strobe low during refresh"); // RULE_13

    property p_row_addr;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $fell(row_strobe_n_o) |-> addr_o == row_q ##1 addr_o == row_q;
    endproperty
    a_row_addr: assert property (p_row_addr) else $error("row byte not held"); // RULE_21

    property p_early_wr;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $fell(col_strobe_n_o) && we_q |-> !write_n_o && $past(!write_n_o) && dq_oe_o;
    endproperty
    a_early_wr: assert property (p_early_wr) else $error("write not early"); // RULE_01

    property p_page;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $fell(col_strobe_n_o) |-> !row_strobe_n_o && $past(!row_strobe_n_o, 2);
    endproperty
    a_page: assert property (p_page) else $error("column strobe without open row"); // RULE_05

    property p_ref_late;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        late_q < 12'h900;
    endproperty
    a_ref_late: assert property (p_ref_late) else $error("refresh overdue"); // RULE_06

    property p_init;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        !row_strobe_n_o |-> dum_q == 4'(`DMC_DUMMY_CYCLES);
    endproperty
    a_init: assert property (p_init) else $error("access before dummy cycles"); // RULE_20

    property p_hidden;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $fell(refresh_n_o) && !col_strobe_n_o |-> (!col_strobe_n_o && !refresh_n_o)[*8];
    endproperty
    a_hidden: assert property (p_hidden) else $error("hidden refresh lost data"); // RULE_18

    property p_precharged;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $fell(refresh_n_o) |-> $past(row_strobe_n_o, 20) && $past(row_strobe_n_o, 1);
    endproperty
    a_precharged: assert property (p_precharged) else $error("refresh before precharge"); // RULE_10

    property p_self;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        st_q == DMC_SELF && sleep_i |=> !refresh_n_o && row_strobe_n_o;
    endproperty
    a_self: assert property (p_self) else $error("self refresh not held"); // RULE_14
endmodule : dmc_ctrl
`default_nettype wire

// ### bench/dmc_mem_model.sv
// Behavioural multiplexed-address dynamic memory facing the controller pins.
`timescale 1ns/1ps
`default_nettype none
module dmc_mem_model #(
    parameter int ACC_NS = 75
) (
    input wire logic row_n_i,
    input wire logic col_n_i,
    input wire logic wr_n_i,
    input wire logic ref_n_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] d_i,
    output logic [7:0] q_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] row_q;
    logic [7:0] col_q;
    logic [6:0] refresh_row_address = 7'h00;
    int ref_pulses = 0;
    // An undriven refresh pin reads high through the pull-up.
    wire ref_w = (ref_n_i === 1'b0) ? 1'b0 : 1'b1;
    initial q_o = 8'h3C;
    // The row byte is latched on the row strobe fall.
    always @(negedge row_n_i) row_q = a_i;
    // Early writes are stored and never drive the pins; reads show after access time.
    always @(negedge col_n_i) begin
        col_q = a_i;
        if (!wr_n_i) begin
            mem[{col_q, row_q}] = d_i;
        end else begin
            #(ACC_NS);
            if (!col_n_i) q_o = mem[{col_q, row_q}];
        end
    end
    // Pins float on the column strobe rise, so they stop showing the old byte.
    always @(posedge col_n_i) q_o = ~q_o;
    // The counter supplies the row and steps when each refresh pulse ends.
    always @(negedge ref_w) begin
        ref_pulses++;
        @(posedge ref_w);
        refresh_row_address = refresh_row_address + 7'h01;
    end
    // Held low with the row strobe high, the part refreshes itself every 12 us; a short
    // automatic pulse never reaches the first step, so it cannot count twice.
    initial forever begin
        @(negedge ref_w);
        #8000;
        while (!ref_w && row_n_i) begin
            refresh_row_address = refresh_row_address + 7'h01;
            #12000;
        end
    end
endmodule : dmc_mem_model
`default_nettype wire

// ### bench/dmc_ctrl_test.sv
// Self-checking bench for the dynamic memory controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end
module dmc_ctrl_test;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic req = 1'b0;
    logic we = 1'b0;
    logic keep = 1'b0;
    logic sleep = 1'b0;
    logic ce = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic ready, done, rvalid, init_done, ras_n, cas_n, wr_n, ref_n, oe;
    logic [7:0] rdata, pin_a, dq_o, dq_i;
    logic [6:0] pre;
    int error_cnt = 0;
    int compares = 0;
    int ras_falls = 0;
    int n;
    initial forever #2.5 ref_clk = ~ref_clk;
    // Short power-up pause keeps the run brief.
    dmc_ctrl #(.POWERUP_CYC(50)) uut (.ref_clk_i(ref_clk), .nrst_i(nrst), .ce_i(ce),
        .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wdata), .keep_page_i(keep),
        .sleep_i(sleep), .ready_o(ready), .done_o(done), .rvalid_o(rvalid),
        .rdata_o(rdata), .init_done_o(init_done), .row_strobe_n_o(ras_n),
        .col_strobe_n_o(cas_n), .write_n_o(wr_n), .refresh_n_o(ref_n), .addr_o(pin_a),
        .dq_o(dq_o), .dq_oe_o(oe), .dq_i(dq_i));
    dmc_mem_model dev (.row_n_i(ras_n), .col_n_i(cas_n), .wr_n_i(wr_n), .ref_n_i(ref_n),
        .a_i(pin_a), .d_i(dq_o), .q_o(dq_i));
    ////////////////////////////////////////////////////////////////////////////////
    // Pin watchers run for the whole test.
    always @(negedge ref_clk) if (!ras_n && !ref_n) `CHK(ras_n, 1'b1)
    always @(negedge ras_n) ras_falls++;
    always @(negedge cas_n) `CHK(oe, ~wr_n)
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    // Every polling wait goes through here, so a hang ends the run as a failure.
    task automatic bump();
        n++;
        if (n > 40000) begin
            error_cnt++;
            conclude();
        end
        @(negedge ref_clk);
    endtask : bump
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        req = 1'b1;
        we = w;
        addr = a;
        wdata = d;
        n = 0;
        while (!ready) bump();
        @(negedge ref_clk);
        req = 1'b0;
        while (!done) bump();
    endtask : acc
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, e)
    endtask : rd
    task automatic t_init();
        `CHK(ras_n & cas_n & wr_n & ref_n, 1'b1)
        `CHK(oe, 1'b0)
        nrst = 1'b1;
        n = 0;
        while (!init_done) bump();
        `CHK(dev.ref_pulses, 8)
    endtask : t_init
    // Two rows written back to back, then read back.
    task automatic t_rw();
        acc(1'b1, 16'h1234, 8'h5A);
        acc(1'b1, 16'h1235, 8'hA5);
        `CHK(dev.mem[16'h1234], 8'h5A)
        rd(16'h1235, 8'hA5);
        rd(16'h1234, 8'h5A);
    endtask : t_rw
    // Page mode starts just after a refresh so none falls inside it.
    task automatic t_page();
        int base;
        n = 0;
        while (ref_n) bump();
        while (!ref_n) bump();
        keep = 1'b1;
        base = ras_falls;
        for (int i = 0; i < 4; i++) acc(1'b1, {i[7:0], 8'h40}, 8'hC0 + i[7:0]);
        for (int i = 0; i < 4; i++) rd({i[7:0], 8'h40}, 8'hC0 + i[7:0]);
        keep = 1'b0;
        `CHK(ras_falls - base, 1)
    endtask : t_page
    // Refresh pulses come often enough for 128 rows in 2 ms.
    task automatic t_refresh();
        n = 0;
        while (ref_n) bump();
        pre = dev.refresh_row_address;
        n = 0;
        while (!ref_n) bump();
        while (ref_n) bump();
        `CHK((n <= 3125) && (n > 52), 1'b1)
        `CHK(dev.refresh_row_address, pre + 7'h01)
    endtask : t_refresh
    // A page read is placed so the next refresh falls due while its column strobe is low:
    // 3067 cycles after a refresh pulse ends the interval runs out mid-access.
    task automatic t_hidden();
        n = 0;
        while (!ref_n) bump();
        keep = 1'b1;
        repeat (3067) @(negedge ref_clk);
        rd(16'h1234, 8'h5A);
        rd(16'h1234, 8'h5A);
        n = 0;
        while (ref_n) bump();
        `CHK({ras_n, cas_n}, 2'b10)
        `CHK(dq_i, 8'h5A)
        keep = 1'b0;
        while (!ref_n) bump();
        `CHK(rdata, 8'h5A)
    endtask : t_hidden
    task automatic t_self();
        sleep = 1'b1;
        n = 0;
        while (ref_n) bump();
        pre = dev.refresh_row_address;
        repeat (5000) @(negedge ref_clk);
        `CHK(ready, 1'b0)
        `CHK({ref_n, ras_n}, 2'b01)
        `CHK(dev.refresh_row_address != pre, 1'b1)
        // With the clock enable low the request to leave self refresh is not seen yet.
        ce = 1'b0;
        sleep = 1'b0;
        repeat (100) @(negedge ref_clk);
        `CHK({ref_n, ras_n}, 2'b01)
        ce = 1'b1;
        rd(16'h1234, 8'h5A);
    endtask : t_self
    initial begin
        repeat (6) @(negedge ref_clk);
        t_init();
        t_rw();
        t_page();
        t_refresh();
        t_hidden();
        t_self();
        conclude();
    end
endmodule : dmc_ctrl_test
`default_nettype wire
